// File: logic/flash_seq_defines.svh
/*
 * constants of the flash host controller: register map, field positions,
 * flash command codes, operation codes and bus-cycle timing.
 * assumes inclusion by the package and the controller only.
 */
`ifndef FLASH_SEQ_DEFINES_SVH
`define FLASH_SEQ_DEFINES_SVH

// flash pin widths
`define FL_ADDR_W        22
`define FL_DQ_W          16

// register byte offsets
`define REG_CTRL         8'h00
`define REG_ADDR         8'h04
`define REG_DATA         8'h08
`define REG_COUNT        8'h0C
`define REG_CMD          8'h10
`define REG_STATUS       8'h14
`define REG_RDATA        8'h18
`define REG_BUF_BASE     8'h40
`define REG_BUF_END      8'hC0

// ctrl fields
`define CTRL_WP          0
`define CTRL_BYTE        1
`define CTRL_ALT         2
`define CTRL_RP          3
// cmd fields
`define CMD_NOWAIT       4

// operation codes written to the cmd register
`define OP_CHIP_ERASE    4'h1
`define OP_WORD_WRITE    4'h2
`define OP_BUF_WRITE     4'h3
`define OP_SUSPEND       4'h4
`define OP_RESUME        4'h5
`define OP_CLEAR         4'h6
`define OP_READ_ARRAY    4'h7
`define OP_POLL          4'h8

// flash command codes and buffered write count limits
`define FC_CONFIRM       8'hD0
`define FC_WRITE         8'h40
`define FC_WRITE_ALT     8'h10
`define FC_BUF_SETUP     8'hE8
`define FC_CHIP_SETUP    8'h30
`define FC_SUSPEND       8'hB0
`define FC_RESUME        8'hD0
`define FC_CLEAR         8'h50
`define FC_READ_ARRAY    8'hFF
`define BW_MAX_X8        5'h1F
`define BW_MAX_X16       5'h0F

// status bit positions
`define ST_READY         7
`define ST_SUSP          6
`define ST_ERASE_ERR     5
`define ST_PROG_ERR      4
`define XST_BUF_AVAIL    7

// timing
`define CLK_NS           10
`define T_WE_LOW_NS      50
`define T_ACCESS_NS      100
`define WE_CYC           ((`T_WE_LOW_NS + `CLK_NS - 1) / `CLK_NS)
`define ACC_CYC          ((`T_ACCESS_NS + `CLK_NS - 1) / `CLK_NS)
`define HOLD_CYC         8'h01

`endif

// File: logic/flash_seq_pkg.sv
/*
 * types of the flash host controller: sequencer steps, bus phases,
 * flash pin bundle and the whole controller state.
 * assumes flash_seq_defines.svh on the include path.
 */
`include "flash_seq_defines.svh"

package flash_seq_pkg;

    typedef enum logic [3:0] {
        S_IDLE, S_CHIP_SETUP, S_CHIP_CONF, S_WW_SETUP, S_WW_DATA, S_BW_SETUP, S_BW_XSTAT,
        S_BW_COUNT, S_BW_DATA, S_BW_CONF, S_CMD1, S_RD_ARRAY, S_POLL
    } step_e;

    typedef enum logic [1:0] {P_NONE, P_WR, P_RD} phase_e;

    typedef struct packed {
        logic [`FL_ADDR_W-1:0] addr;
        logic [`FL_DQ_W-1:0]   dq;
        logic                  dq_oe;
        logic                  ce_n;
        logic                  oe_n;
        logic                  we_n;
        logic                  write_protect_pin;
        logic                  byte_n;
        logic                  reset_powerdown_n;
    } flash_out_s;

    typedef struct packed {
        step_e                 step;
        phase_e                phase;
        logic                  inflight;
        logic [7:0]            cnt;
        logic [3:0]            op;
        logic                  no_wait;
        logic [4:0]            idx;
        flash_out_s            flash;
        logic                  alt_setup;
        logic [7:0]            status_byte;
        logic [7:0]            ext_status;
        logic [15:0]           rdata;
        logic [15:0]           rd_val;
        logic                  busy;
        logic                  refused;
        logic                  erase_running;
        logic                  prog_in_suspend;
        logic                  suspended;
        logic                  rb_level;
        logic [`FL_ADDR_W-1:0] addr;
        logic [15:0]           data;
        logic [4:0]            count;
        logic [31:0][15:0]     buffer;
        logic                  pend_wr;
        logic                  pend_ok;
        logic [7:0]            pend_addr;
        logic [31:0]           hrdata;
    } state_s;

endpackage

// File: logic/flash_host_ctrl.sv
/*
 * host-side controller for a parallel flash: software orders chip erase,
 * word write, buffered write, suspend/resume (suspend refused while an erase runs) over ahb-lite registers,
 * and the block plays the command sequences out on the flash pins.
 * assumes one ahb-lite master, flash inputs synchronous to hclk, and an
 * external pull-up on the ready/busy line.
 */
// Register access over AHB-Lite and the register addresses were decided locally.
`timescale 1ns/10ps
`include "flash_seq_defines.svh"

module flash_host_ctrl #(
    parameter int BUF_DEPTH = 32
) (
    // clock and reset
    input  wire logic                       hclk,
    input  wire logic                       hresetn,
    // ahb-lite slave
    input  wire logic                       hsel,
    input  wire logic [31:0]                haddr,
    input  wire logic [1:0]                 htrans,
    input  wire logic                       hwrite,
    input  wire logic [2:0]                 hsize,
    input  wire logic [31:0]                hwdata,
    input  wire logic                       hready,
    output logic                            hreadyout,
    output logic [31:0]                     hrdata,
    output logic                            hresp,
    // flash pins
    output flash_seq_pkg::flash_out_s       flash_o,
    input  wire logic [`FL_DQ_W-1:0]        flash_dq_in,
    input  wire logic                       ready_busy_level
);

    if (BUF_DEPTH < 2 || BUF_DEPTH > 32) begin : g_chk
        $error("buffer depth must lie in 2..32");
    end

    localparam flash_seq_pkg::state_s RST = '{
        flash: '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, byte_n: 1'b1, reset_powerdown_n: 1'b1, default: '0},
        step: flash_seq_pkg::S_IDLE, phase: flash_seq_pkg::P_NONE, default: '0};

    flash_seq_pkg::state_s s;
    flash_seq_pkg::state_s next_s;

    function automatic logic [31:0] read_mux(input flash_seq_pkg::state_s st, input logic [7:0] a);
        logic [31:0] r;
        r = 32'h0000_0000;
        if (a >= `REG_BUF_BASE && a < `REG_BUF_END) begin
            r = {16'h0000, st.buffer[5'((a - `REG_BUF_BASE) >> 2)]};
        end else begin
            case (a)
                `REG_CTRL:   r = {28'h000_0000, st.flash.reset_powerdown_n, st.alt_setup, ~st.flash.byte_n,
                                  st.flash.write_protect_pin};
                `REG_ADDR:   r = 32'(st.addr);
                `REG_DATA:   r = {16'h0000, st.data};
                `REG_COUNT:  r = {27'h000_0000, st.count};
                `REG_STATUS: r = {10'h000, st.rb_level, st.prog_in_suspend, st.erase_running, st.suspended,
                                  st.refused, st.busy, st.ext_status, st.status_byte};
                `REG_RDATA:  r = {16'h0000, st.rdata};
                default:     r = 32'h0000_0000;
            endcase
        end
        return r;
    endfunction

    always_comb begin
        logic                  go_wr;
        logic                  go_rd;
        logic [`FL_ADDR_W-1:0] wa;
        logic [15:0]           wd;
        logic                  ok;
        logic [4:0]            lim;
        next_s = s;
        go_wr  = 1'b0;
        go_rd  = 1'b0;
        wa     = s.addr;
        wd     = 16'h0000;
        ok     = 1'b1;
        lim    = s.flash.byte_n ? `BW_MAX_X16 : `BW_MAX_X8;
        // ready/busy: low while busy, floats high when ready
        // level sampled
        next_s.rb_level = ready_busy_level;

        // flash bus cycle progress
        case (s.phase)
            flash_seq_pkg::P_WR: begin
                if (s.cnt != 8'h00) begin
                    next_s.cnt = s.cnt - 8'h01;
                end else if (!s.flash.we_n) begin
                    next_s.flash.we_n = 1'b1;
                    next_s.cnt        = `HOLD_CYC;
                end else begin
                    next_s.flash.ce_n  = 1'b1;
                    next_s.flash.dq_oe = 1'b0;
                    next_s.phase       = flash_seq_pkg::P_NONE;
                end
            end
            flash_seq_pkg::P_RD: begin
                if (s.cnt != 8'h00) begin
                    next_s.cnt = s.cnt - 8'h01;
                end else begin
                    next_s.rd_val     = flash_dq_in;
                    next_s.flash.oe_n = 1'b1;
                    next_s.flash.ce_n = 1'b1;
                    next_s.phase      = flash_seq_pkg::P_NONE;
                end
            end
            default: ;
        endcase

        // sequencer: issue one bus cycle per step, advance once it is over
        if (s.step != flash_seq_pkg::S_IDLE && s.phase == flash_seq_pkg::P_NONE) begin
            next_s.inflight = ~s.inflight;
            if (!s.inflight) begin
                case (s.step)
                    flash_seq_pkg::S_CHIP_SETUP: begin go_wr = 1'b1; wd = 16'(`FC_CHIP_SETUP); end
                    flash_seq_pkg::S_CHIP_CONF:  begin go_wr = 1'b1; wd = 16'(`FC_CONFIRM); end
                    flash_seq_pkg::S_WW_SETUP: begin
                        go_wr = 1'b1;
                        wd    = s.alt_setup ? 16'(`FC_WRITE_ALT) : 16'(`FC_WRITE);
                    end
                    flash_seq_pkg::S_WW_DATA:  begin go_wr = 1'b1; wd = s.data; end
                    flash_seq_pkg::S_BW_SETUP: begin go_wr = 1'b1; wd = 16'(`FC_BUF_SETUP); end
                    flash_seq_pkg::S_BW_COUNT: begin go_wr = 1'b1; wd = 16'(s.count); end
                    flash_seq_pkg::S_BW_DATA: begin
                        go_wr = 1'b1;
                        wa    = s.addr + `FL_ADDR_W'(s.idx);
                        wd    = s.buffer[s.idx];
                    end
                    flash_seq_pkg::S_BW_CONF: begin go_wr = 1'b1; wd = 16'(`FC_CONFIRM); end
                    flash_seq_pkg::S_CMD1: begin
                        go_wr = 1'b1;
                        case (s.op)
                            `OP_SUSPEND: wd = 16'(`FC_SUSPEND);
                            `OP_RESUME:  wd = 16'(`FC_RESUME);
                            `OP_CLEAR:   wd = 16'(`FC_CLEAR);
                            default:     wd = 16'(`FC_READ_ARRAY);
                        endcase
                    end
                    default: go_rd = 1'b1;
                endcase
            end else begin
                case (s.step)
                    flash_seq_pkg::S_CHIP_SETUP: next_s.step = flash_seq_pkg::S_CHIP_CONF;
                    flash_seq_pkg::S_CHIP_CONF: begin
                        next_s.erase_running = 1'b1;
                        next_s.step = s.no_wait ? flash_seq_pkg::S_IDLE : flash_seq_pkg::S_POLL;
                    end
                    flash_seq_pkg::S_WW_SETUP: next_s.step = flash_seq_pkg::S_WW_DATA;
                    flash_seq_pkg::S_BW_SETUP: next_s.step = flash_seq_pkg::S_BW_XSTAT;
                    flash_seq_pkg::S_BW_XSTAT: begin
                        next_s.ext_status = s.rd_val[7:0];
                        next_s.step = s.rd_val[`XST_BUF_AVAIL] ? flash_seq_pkg::S_BW_COUNT
                                                               : flash_seq_pkg::S_BW_SETUP;
                    end
                    flash_seq_pkg::S_BW_COUNT: begin
                        next_s.idx  = 5'h00;
                        next_s.step = flash_seq_pkg::S_BW_DATA;
                    end
                    flash_seq_pkg::S_BW_DATA: begin
                        next_s.idx  = s.idx + 5'h01;
                        next_s.step = (s.idx == s.count) ? flash_seq_pkg::S_BW_CONF : flash_seq_pkg::S_BW_DATA;
                    end
                    flash_seq_pkg::S_WW_DATA, flash_seq_pkg::S_BW_CONF: begin
                        next_s.prog_in_suspend = s.prog_in_suspend | s.suspended;
                        next_s.step = s.no_wait ? flash_seq_pkg::S_IDLE : flash_seq_pkg::S_POLL;
                    end
                    flash_seq_pkg::S_CMD1: begin
                        case (s.op)
                            `OP_SUSPEND: next_s.step = flash_seq_pkg::S_POLL;
                            `OP_RESUME: begin
                                next_s.suspended = 1'b0;
                                next_s.step      = flash_seq_pkg::S_IDLE;
                            end
                            `OP_CLEAR: begin
                                next_s.status_byte = 8'h00;
                                next_s.step        = flash_seq_pkg::S_IDLE;
                            end
                            default: next_s.step = flash_seq_pkg::S_RD_ARRAY;
                        endcase
                    end
                    flash_seq_pkg::S_RD_ARRAY: begin
                        next_s.rdata = s.rd_val;
                        next_s.step  = flash_seq_pkg::S_IDLE;
                    end
                    flash_seq_pkg::S_POLL: begin
                        next_s.status_byte = s.rd_val[7:0];
                        // done when ready flag reads one, and for a suspend the suspend flag too
                        if (s.rd_val[`ST_READY] && (s.op != `OP_SUSPEND || s.rd_val[`ST_SUSP])) begin
                            next_s.erase_running   = 1'b0;
                            next_s.prog_in_suspend = 1'b0;
                            next_s.suspended       = s.suspended | (s.op == `OP_SUSPEND);
                            next_s.step            = flash_seq_pkg::S_IDLE;
                        end
                    end
                    default: next_s.step = flash_seq_pkg::S_IDLE;
                endcase
            end
        end
        if (next_s.step == flash_seq_pkg::S_IDLE) begin
            next_s.busy = 1'b0;
        end

        if (go_wr) begin
            next_s.phase       = flash_seq_pkg::P_WR;
            next_s.flash.addr  = wa;
            next_s.flash.dq    = wd;
            next_s.flash.dq_oe = 1'b1;
            next_s.flash.ce_n  = 1'b0;
            next_s.flash.we_n  = 1'b0;
            next_s.cnt         = 8'(`WE_CYC - 1);
        end
        if (go_rd) begin
            next_s.phase      = flash_seq_pkg::P_RD;
            next_s.flash.addr = s.addr;
            next_s.flash.ce_n = 1'b0;
            next_s.flash.oe_n = 1'b0;
            next_s.cnt        = 8'(`ACC_CYC - 1);
        end

        // ahb-lite: address phase captured, writes land in the data phase
        next_s.pend_wr   = hsel & hready & htrans[1] & hwrite;
        next_s.pend_ok   = (haddr[31:8] == 24'h00_0000);
        next_s.pend_addr = haddr[7:0];
        next_s.hrdata    = (hsel & hready & htrans[1] & ~hwrite & next_s.pend_ok) ? read_mux(s, haddr[7:0])
                                                                                 : 32'h0000_0000;
        if (s.pend_wr && s.pend_ok) begin
            if (s.pend_addr == `REG_CTRL) begin
                next_s.flash.write_protect_pin = hwdata[`CTRL_WP];
                next_s.flash.byte_n            = ~hwdata[`CTRL_BYTE];
                next_s.alt_setup               = hwdata[`CTRL_ALT];
                next_s.flash.reset_powerdown_n = hwdata[`CTRL_RP];
            end else if (!s.busy) begin
                // operands frozen while a sequence runs
                if (s.pend_addr >= `REG_BUF_BASE && s.pend_addr < `REG_BUF_END) begin
                    next_s.buffer[5'((s.pend_addr - `REG_BUF_BASE) >> 2)] = hwdata[15:0];
                end
                case (s.pend_addr)
                    `REG_ADDR:  next_s.addr  = hwdata[`FL_ADDR_W-1:0];
                    `REG_DATA:  next_s.data  = hwdata[15:0];
                    `REG_COUNT: next_s.count = hwdata[4:0];
                    `REG_CMD: begin
                        next_s.op      = hwdata[3:0];
                        next_s.no_wait = hwdata[`CMD_NOWAIT];
                        case (hwdata[3:0])
                            `OP_CHIP_ERASE: next_s.step = flash_seq_pkg::S_CHIP_SETUP;
                            `OP_WORD_WRITE: next_s.step = flash_seq_pkg::S_WW_SETUP;
                            `OP_BUF_WRITE: begin
                                ok = (s.count <= lim) && (5'(BUF_DEPTH - 1) >= s.count) &&
                                     !s.status_byte[`ST_PROG_ERR] && !s.status_byte[`ST_ERASE_ERR];
                                next_s.step = flash_seq_pkg::S_BW_SETUP;
                            end
                            `OP_SUSPEND: begin
                                ok = !s.erase_running;
                                next_s.step = flash_seq_pkg::S_CMD1;
                            end
                            `OP_RESUME: begin
                                ok = s.suspended && !s.prog_in_suspend;
                                next_s.step = flash_seq_pkg::S_CMD1;
                            end
                            `OP_CLEAR, `OP_READ_ARRAY: next_s.step = flash_seq_pkg::S_CMD1;
                            `OP_POLL:  next_s.step = flash_seq_pkg::S_POLL;
                            default:   ok = 1'b0;
                        endcase
                        if (!ok) begin
                            next_s.step = flash_seq_pkg::S_IDLE;
                        end
                        next_s.refused  = ~ok;
                        next_s.busy     = ok;
                        next_s.inflight = 1'b0;
                    end
                    default: ;
                endcase
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s <= RST;
        end else begin
            s <= next_s;
        end
    end

    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = s.hrdata;
    assign flash_o   = s.flash;

endmodule

// File: sim/flash_host_props.sv
/*
 * checker of the flash pin timing driven by the host controller.
 * assumes binding to flash_host_ctrl, one clock domain.
 */
`timescale 1ns/10ps

module flash_host_props (
    // clock and reset
    input wire logic                 hclk,
    input wire logic                 hresetn,
    // flash pins
    input flash_seq_pkg::flash_out_s flash_o
);
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    sequence strobe_low;
        !flash_o.we_n [*5] ##1 flash_o.we_n;
    endsequence
    sequence read_span;
        ##9 !flash_o.oe_n ##1 flash_o.oe_n;
    endsequence
    sequence strobe_tail;
        !flash_o.ce_n ##1 !flash_o.ce_n ##1 flash_o.ce_n;
    endsequence

    a_strobe_width: assert property ($fell(flash_o.we_n) |-> strobe_low)
        else $error("write strobe width wrong");
    a_write_frame: assert property (!flash_o.we_n |-> !flash_o.ce_n && flash_o.dq_oe && flash_o.oe_n)
        else $error("write cycle framing wrong");
    a_write_hold: assert property (!flash_o.we_n |=> $stable(flash_o.addr) && $stable(flash_o.dq))
        else $error("address or data moved under strobe");
    a_cycle_gap: assert property ($rose(flash_o.ce_n) |=> flash_o.ce_n)
        else $error("no idle cycle between flash cycles");
    a_read_width: assert property ($fell(flash_o.oe_n) |-> read_span)
        else $error("read enable width wrong");
    a_read_frame: assert property (!flash_o.oe_n |-> !flash_o.ce_n && !flash_o.dq_oe && flash_o.we_n)
        else $error("read cycle framing wrong");
    a_dq_release: assert property ($rose(flash_o.ce_n) |-> !flash_o.dq_oe)
        else $error("data bus driven while deselected");
    a_we_release: assert property ($rose(flash_o.we_n) |-> strobe_tail)
        else $error("chip select released at wrong time");
endmodule

bind flash_host_ctrl flash_host_props flash_host_props_i (.hclk(hclk), .hresetn(hresetn), .flash_o(flash_o));

// File: sim/flash_dev_model.sv
/*
 * behavioural flash device: command decoder, status and extended status.
 * assumes flash pins change only after hclk edges; busy times are short.
 */
`timescale 1ns/10ps

module flash_dev_model (
    // clock and flash pins
    input wire logic                 hclk,
    input flash_seq_pkg::flash_out_s fo,
    output logic [15:0]              dq_in,
    output logic                     rb_level,
    // fault request from the bench
    input wire logic                 inject_err
);
    logic [7:0]  st = 8'h00, exp = 8'h00, c, last_setup;
    logic [15:0] val, last = 16'h0000, words[$];
    logic        pwe = 1'h1, deny = 1'h1, susp = 1'h0, chip = 1'h0, avail = 1'h0;
    int          ebusy = 0, pbusy = 0, blk = 0, cnt = 0, setups = 0, mode = 0;
    wire         rdy = pbusy == 0 && (ebusy == 0 || susp);
    // low while busy, pull-up level when ready
    assign rb_level = rdy;
    // status, extended status or array data by mode; a released bus shows the inverse of the last value
    assign val = mode == 2 ? 16'hA5C3 ^ fo.addr[15:0] : mode == 1 ? {8'h00, avail, 7'h00} : {8'h00, rdy, susp, st[5:0]};
    assign dq_in = (!fo.ce_n && !fo.oe_n) ? val : ~last;
    always @(posedge hclk) begin
        if (!fo.ce_n && !fo.oe_n)
            last <= val;
        // one block a step, ascending from block 0
        if (ebusy > 0 && !susp) begin
            ebusy--;
            blk++;
        end
        if (pbusy > 0)
            pbusy--;
        if (fo.we_n && !pwe) begin
            c = fo.dq[7:0];
            mode = (exp == 8'h00 && c == 8'hFF) ? 2 : 0;
            case (exp)
                // chip erase confirm or bad sequence
                8'h30: begin
                    exp = 8'h00;
                    if (c == 8'hD0) begin
                        ebusy = 64;
                        blk = 0;
                        chip = 1'h1;
                    end else
                        st[5:4] = 2'h3;
                end
                // data write, fault only on request
                8'h40: begin
                    exp = 8'h00;
                    words.push_back(fo.dq);
                    pbusy = 4;
                    if (inject_err)
                        st[4] = 1'h1;
                end
                8'hE8: begin
                    cnt = fo.dq[4:0];
                    exp = 8'h01;
                end
                8'h01: begin
                    words.push_back(fo.dq);
                    if (cnt-- == 0)
                        exp = 8'h02;
                end
                8'h02: begin
                    exp = 8'h00;
                    if (c == 8'hD0)
                        pbusy = 8;
                    else
                        st[5:4] = 2'h3;
                end
                default: case (c)
                    8'h30: exp = c;
                    8'h40, 8'h10: begin
                        exp = 8'h40;
                        last_setup = c;
                    end
                    // first setup refused, errors block buffering
                    8'hE8: begin
                        setups++;
                        mode = 1;
                        avail = !deny && st[5:4] == 2'h0;
                        deny = 1'h0;
                        if (avail)
                            exp = c;
                    end
                    8'h50: st = 8'h00;
                    // no suspend of a chip erase
                    8'hB0: if (ebusy > 0 && !chip) susp = 1'h1;
                    // resume only after suspended programming ends
                    8'hD0: if (susp && pbusy == 0) susp = 1'h0;
                    default: ;
                endcase
            endcase
        end
        pwe = fo.we_n;
    end
endmodule

// File: sim/tb.sv
/*
 * self-checking bench of the flash host controller over ahb-lite.
 * assumes flash_dev_model on the flash pins and the bound checker.
 */
`timescale 1ns/10ps

module tb;
    logic        hclk = 1'h0, hresetn = 1'h0, hsel = 1'h1, hwrite = 1'h0, inject = 1'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, r, d, a, seed = 32'h5F82;
    logic [1:0]  htrans = 2'h0;
    logic [2:0]  hsize = 3'h2;
    logic        hreadyout, hresp, rbl;
    logic [15:0] dqi, bw[16];
    flash_seq_pkg::flash_out_s fo;
    int          miscompares = 0, tests_run = 0, cyc = 0, i, n;

    flash_host_ctrl #(.BUF_DEPTH(32)) flash_host_ctrl_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .flash_o(fo), .flash_dq_in(dqi),
        .ready_busy_level(rbl));
    flash_dev_model flash_dev_model_i (.hclk(hclk), .fo(fo), .dq_in(dqi), .rb_level(rbl), .inject_err(inject));

    initial forever #5 hclk = ~hclk;

    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // one single word transfer; the slave may stretch either phase
    task automatic bus(input logic w, input logic [31:0] ad, input logic [31:0] wd);
        htrans <= 2'h2;
        haddr <= ad;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'h1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'h1);
        r = hrdata;
    endtask

    // issue an order, then poll status until busy clears
    task automatic run(input logic [31:0] op);
        bus(1'h1, 32'h10, op);
        r = 32'h10000;
        for (int k = 0; k < 3000 && r[16] !== 1'h0; k++)
            bus(1'h0, 32'h14, 32'h0);
        chk(r[16], 32'h0);
    endtask

    always @(posedge hclk) begin
        cyc++;
        if (cyc == 60000) begin
            miscompares++;
            tally_and_finish;
        end
    end

    initial begin
        repeat (12) @(posedge hclk);
        hresetn <= 1'h1;
        @(posedge hclk);
        bus(1'h0, 32'h00, 32'h0);
        chk(r, 32'h8);
        bus(1'h0, 32'h14, 32'h0);
        chk(r, 32'h0020_0000);
        // unmapped places read zero and swallow writes
        bus(1'h1, 32'h104, 32'hFFFF_FFFF);
        bus(1'h0, 32'h104, 32'h0);
        chk(r, 32'h0);
        bus(1'h0, 32'h1C, 32'h0);
        chk(r, 32'h0);
        for (i = 0; i < 2; i++) begin
            a = $random(seed) & 32'h3F_FFFF;
            d = $random(seed) & 32'hFFFF;
            bus(1'h1, 32'h00, 32'h8 | (i << 2));
            bus(1'h1, 32'h04, a);
            bus(1'h1, 32'h08, d);
            run(32'h2);
            chk(r, 32'h0020_0080);
            chk(flash_dev_model_i.last_setup, i ? 8'h10 : 8'h40);
            chk(flash_dev_model_i.words.pop_back(), d);
        end
        run(32'h7);
        bus(1'h0, 32'h18, 32'h0);
        chk(r, {16'h0, a[15:0] ^ 16'hA5C3});
        run(32'h11);
        run(32'h4);
        chk(r[17], 32'h1);
        run(32'h8);
        chk(r & ~32'h20000, 32'h0020_0080);
        chk(flash_dev_model_i.blk, 32'h40);
        run(32'h5);
        chk(r[17], 32'h1);
        bus(1'h1, 32'h00, 32'h8);
        bus(1'h1, 32'h0C, 32'h10);
        run(32'h3);
        chk(r[17], 32'h1);
        n = $random(seed) & 15;
        bus(1'h1, 32'h0C, n);
        for (i = 0; i <= n; i++) begin
            bw[i] = 16'($random(seed));
            bus(1'h1, 32'h40 + 4 * i, {16'h0, bw[i]});
        end
        flash_dev_model_i.words.delete();
        run(32'h3);
        chk(r & ~32'h20000, 32'h0020_8080);
        chk(flash_dev_model_i.setups, 32'h2);
        chk(flash_dev_model_i.words.size(), n + 1);
        for (i = 0; i <= n; i++)
            chk(flash_dev_model_i.words[i], bw[i]);
        inject <= 1'h1;
        run(32'h2);
        chk(r[7:0], 32'h90);
        inject <= 1'h0;
        run(32'h3);
        chk(r[17], 32'h1);
        run(32'h6);
        chk(r[7:0], 32'h0);
        run(32'h3);
        chk(flash_dev_model_i.setups, 32'h3);
        tally_and_finish;
    end
endmodule
